//--- rtl/pdmc_regs.svh
`ifndef PDMC_REGS_SVH
`define PDMC_REGS_SVH
`define PDMC_NPINS      8
`define PDMC_DM_W       3
`define PDMC_DM_HIZ_ANA 3'h0
`define PDMC_DM_HIZ_DIG 3'h1
`define PDMC_DM_RES_UP  3'h2
`define PDMC_DM_RES_DN  3'h3
`define PDMC_DM_OD_LO   3'h4
`define PDMC_DM_OD_HI   3'h5
`define PDMC_DM_STRONG  3'h6
`define PDMC_DM_RES_UD  3'h7
`define PDMC_USB_HI     7
`define PDMC_USB_LO     6
`define PDMC_IT_NONE    2'h0
`define PDMC_IT_RISE    2'h1
`define PDMC_IT_FALL    2'h2
`define PDMC_IT_BOTH    2'h3
`define PDMC_PIN_DM_LSB  0
`define PDMC_PIN_DR_BIT  3
`define PDMC_PIN_BYP_BIT 4
`define PDMC_PIN_DIE_BIT 5
`define PDMC_PIN_IT_LSB  6
`endif

//--- rtl/pdmc_pkg.sv
package pdmc_pkg;
  // Driver strength per data level
  typedef enum logic [1:0] {
    PDMC_DRV_HIZ    = 2'h0,
    PDMC_DRV_RES    = 2'h1,
    PDMC_DRV_STRONG = 2'h2
  } pdmc_drv_t;

  typedef struct packed {
    pdmc_drv_t hi;
    pdmc_drv_t lo;
    logic      out;
    logic      in_en;
  } pdmc_pad_t;

  // Per-pin combined register: it, die, byp, dr, dm
  typedef struct packed {
    logic [1:0] int_type;
    logic       din_en;
    logic       hw_out_sel;
    logic       out_val;
    logic [2:0] drive_mode_field;
  } pdmc_pin_cfg_t;

  typedef enum logic [2:0] {
    PDMC_ST_RESET = 3'b001,
    PDMC_ST_LOAD  = 3'b010,
    PDMC_ST_RUN   = 3'b100
  } pdmc_state_t;
endpackage

//--- rtl/pdmc_pin.sv
`timescale 1ns/10ps
`include "pdmc_regs.svh"
module pdmc_pin (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [2:0]        drive_mode_i,
  input  wire logic              usb_pin_i,
  input  wire logic              usb_mode_i,
  input  wire logic              sio_reg_i,
  input  wire logic              out_val_i,
  input  wire logic              pin_sync_i,
  input  wire logic [1:0]        int_type_i,
  input  wire logic              din_en_i,
  output pdmc_pkg::pdmc_pad_t    pad_o,
  output logic                   pin_level_o,
  output logic                   fabric_in_o,
  output logic                   edge_o
);
  import pdmc_pkg::*;

  pdmc_pad_t pad;
  pdmc_pad_t next_pad;
  logic      pin_level;
  logic      next_pin_level;
  logic      fabric_in;
  logic      next_fabric_in;
  logic      edge_ev;
  logic      next_edge_ev;
  logic      in_on;

  always_comb begin
    next_pad       = '{PDMC_DRV_HIZ, PDMC_DRV_HIZ, out_val_i, 1'b0};
    if (usb_pin_i) begin
      next_pad.in_en = !usb_mode_i;
      if (usb_mode_i) begin
        // USB core owns the pad here
        next_pad.hi = PDMC_DRV_HIZ;
      end else if (drive_mode_i[0]) begin
        next_pad.hi = PDMC_DRV_STRONG;
        next_pad.lo = PDMC_DRV_STRONG;
      end else begin
        next_pad.hi = drive_mode_i[1] ? PDMC_DRV_RES : PDMC_DRV_HIZ;
        next_pad.lo = PDMC_DRV_STRONG;
      end
    end else begin
      next_pad.in_en = (drive_mode_i != `PDMC_DM_HIZ_ANA);
      case (drive_mode_i)
        `PDMC_DM_RES_UP: begin
          next_pad.hi = PDMC_DRV_RES;
          next_pad.lo = PDMC_DRV_STRONG;
        end
        `PDMC_DM_RES_DN: begin
          next_pad.hi = PDMC_DRV_STRONG;
          next_pad.lo = PDMC_DRV_RES;
        end
        `PDMC_DM_OD_LO: begin
          next_pad.lo = PDMC_DRV_STRONG;
        end
        `PDMC_DM_OD_HI: begin
          next_pad.hi = PDMC_DRV_STRONG;
        end
        `PDMC_DM_STRONG: begin
          next_pad.hi = PDMC_DRV_STRONG;
          next_pad.lo = PDMC_DRV_STRONG;
        end
        `PDMC_DM_RES_UD: begin
          next_pad.hi = PDMC_DRV_RES;
          next_pad.lo = PDMC_DRV_RES;
        end
        default: begin
          next_pad.hi = PDMC_DRV_HIZ;
        end
      endcase
      // Regulated special pin: resistive legs fall back to strong
      if (sio_reg_i && next_pad.hi == PDMC_DRV_RES)
        next_pad.hi = PDMC_DRV_STRONG;
      if (sio_reg_i && next_pad.lo == PDMC_DRV_RES)
        next_pad.lo = PDMC_DRV_STRONG;
    end
  end

  assign in_on = pad.in_en;

  always_comb begin
    next_pin_level = in_on ? pin_sync_i : 1'b0;
    next_fabric_in = in_on && din_en_i && pin_sync_i;
    next_edge_ev   = 1'b0;
    if (in_on) begin
      case (int_type_i)
        `PDMC_IT_RISE: next_edge_ev = pin_sync_i && !pin_level;
        `PDMC_IT_FALL: next_edge_ev = !pin_sync_i && pin_level;
        `PDMC_IT_BOTH: next_edge_ev = pin_sync_i != pin_level;
        default:       next_edge_ev = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad       <= '{PDMC_DRV_HIZ, PDMC_DRV_HIZ, 1'b0, 1'b0};
      pin_level <= 1'b0;
      fabric_in <= 1'b0;
      edge_ev   <= 1'b0;
    end else begin
      pad       <= next_pad;
      pin_level <= next_pin_level;
      fabric_in <= next_fabric_in;
      edge_ev   <= next_edge_ev;
    end
  end

  assign pad_o       = pad;
  assign pin_level_o = pin_level;
  assign fabric_in_o = fabric_in;
  assign edge_o      = edge_ev;
endmodule

//--- rtl/pdmc_port.sv
// Contract
// - Each pin has a three-bit drive-mode field choosing one of eight modes.
// - Mode 0 disables driver and input buffer; it is the reset mode.
// - In mode 0 no pin value reaches pin-level register or fabric.
// - Mode 1 keeps driver off and enables the digital input buffer.
// - Modes 2, 3, 7 give resistive high/strong low, strong/resistive, both.
// - Mode 4 is high-Z for 1, strong low for 0.
// - Mode 5 is strong high for 1, high-Z for 0.
// - Mode 6 drives strong high and strong low.
// - Output value comes from fabric when bypass set, else data register.
// - Pin input updates pin level only when input buffer on; fabric only when input enabled too.
// - Regulated special pins offer no resistive drive configurations; not applied to USB pins 7,6, where pull 1 still gives resistive high.
// - Pin-level reads and output-value writes use separate registers.
// - Config reachable as port-wide and per-pin combined registers.
// - Each pin interrupts on rising, falling or both edges.
// - The port has its own interrupt request covering all pins.
// - Reset state of drive modes is programmable, loaded at power-on.
// - USB pins 7,6 use drive-enable bits and pull-enable bits.
// - USB pin, pull 0 and drive 0: open drain low.
// - USB pin, pull 1 and drive 0: resistive high, strong low.
// - In USB mode drive and pull bits have no effect.
// - Port-wide drive-mode writes leave USB pins' drive bits unchanged.
`timescale 1ns/10ps
`include "pdmc_regs.svh"
module pdmc_port (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [7:0]             reset_dm_high_i,
  input  wire logic [7:0]             reset_dm_mid_i,
  input  wire logic [7:0]             reset_dm_low_i,
  input  wire logic [7:0]             port_drive_mode_bit_high_i,
  input  wire logic [7:0]             port_drive_mode_bit_mid_i,
  input  wire logic [7:0]             port_drive_mode_bit_low_i,
  input  wire logic                   port_dm_wr_i,
  input  wire logic [7:0]             port_output_value_reg_i,
  input  wire logic                   port_dr_wr_i,
  input  wire logic [7:0]             hardware_output_select_i,
  input  wire logic [7:0]             din_en_i,
  input  wire logic [15:0]            int_type_i,
  input  wire logic                   port_cfg_wr_i,
  input  wire logic [2:0]             pin_sel_i,
  input  wire pdmc_pkg::pdmc_pin_cfg_t pin_cfg_i,
  input  wire logic                   pin_wr_i,
  input  wire logic [7:0]             usb_pin_drive_enable_bits_i,
  input  wire logic [7:0]             usb_pin_pull_enable_bits_i,
  input  wire logic                   usb_wr_i,
  input  wire logic                   usb_present_i,
  input  wire logic                   usb_mode_i,
  input  wire logic [7:0]             sio_pin_i,
  input  wire logic [7:0]             sio_regulated_i,
  input  wire logic [7:0]             fabric_out_i,
  input  wire logic [7:0]             int_clear_i,
  input  wire logic [7:0]             pin_i,
  output logic [7:0]                  pin_o,
  output logic [7:0]                  pin_oe_n_o,
  output logic [7:0]                  pin_res_o,
  output logic [7:0]                  pin_level_reg_o,
  output logic [7:0]                  fabric_in_o,
  output logic [7:0]                  int_status_o,
  output logic                        port_irq_o,
  output pdmc_pkg::pdmc_pin_cfg_t     pin_cfg_o,
  output logic [7:0]                  output_value_reg_o
);
  import pdmc_pkg::*;

  pdmc_state_t     state;
  pdmc_state_t     next_state;
  logic [2:0]      dm [`PDMC_NPINS];
  logic [2:0]      next_dm [`PDMC_NPINS];
  logic [7:0]      output_value_reg;
  logic [7:0]      next_output_value_reg;
  logic [7:0]      byp;
  logic [7:0]      next_byp;
  logic [7:0]      die;
  logic [7:0]      next_die;
  logic [15:0]     itype;
  logic [15:0]     next_itype;
  logic [7:0]      stat;
  logic [7:0]      next_stat;
  logic            irq;
  logic            next_irq;
  logic [7:0]      sync1;
  logic [7:0]      sync2;
  logic [7:0]      out_mux;
  logic [7:0]      lvl;
  logic [7:0]      fin;
  logic [7:0]      edg;
  logic [7:0]      is_usb;
  logic [7:0]      pd_o;
  logic [7:0]      pd_oe_n;
  logic [7:0]      pd_res;
  logic [7:0]      next_pd_o;
  logic [7:0]      next_pd_oe_n;
  logic [7:0]      next_pd_res;
  pdmc_pad_t       pad [`PDMC_NPINS];
  pdmc_pin_cfg_t   rd_cfg;
  pdmc_pin_cfg_t   next_rd_cfg;

  // Two-flop input synchroniser
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  always_comb begin
    is_usb = 8'h00;
    is_usb[`PDMC_USB_HI] = usb_present_i;
    is_usb[`PDMC_USB_LO] = usb_present_i;
  end

  // Configuration registers
  always_comb begin
    next_state            = state;
    next_dm               = dm;
    next_output_value_reg = output_value_reg;
    next_byp              = byp;
    next_die              = die;
    next_itype            = itype;
    case (state)
      PDMC_ST_RESET: next_state = PDMC_ST_LOAD;
      PDMC_ST_LOAD: begin
        // Straps give each pin its power-on drive mode
        for (int i = 0; i < `PDMC_NPINS; i++)
          next_dm[i] = {reset_dm_high_i[i], reset_dm_mid_i[i],
                        reset_dm_low_i[i]};
        next_state = PDMC_ST_RUN;
      end
      PDMC_ST_RUN: begin
        if (port_dm_wr_i) begin
          for (int i = 0; i < `PDMC_NPINS; i++)
            if (!is_usb[i])
              next_dm[i] = {port_drive_mode_bit_high_i[i],
                            port_drive_mode_bit_mid_i[i],
                            port_drive_mode_bit_low_i[i]};
        end
        if (usb_wr_i) begin
          for (int i = 0; i < `PDMC_NPINS; i++)
            if (is_usb[i])
              next_dm[i] = {1'b0, usb_pin_pull_enable_bits_i[i],
                            usb_pin_drive_enable_bits_i[i]};
        end
        if (port_dr_wr_i)
          next_output_value_reg = port_output_value_reg_i;
        if (port_cfg_wr_i) begin
          next_byp   = hardware_output_select_i;
          next_die   = din_en_i;
          next_itype = int_type_i;
        end
        if (pin_wr_i) begin
          next_dm[pin_sel_i] = pin_cfg_i.drive_mode_field;
          next_output_value_reg[pin_sel_i] = pin_cfg_i.out_val;
          next_byp[pin_sel_i] = pin_cfg_i.hw_out_sel;
          next_die[pin_sel_i] = pin_cfg_i.din_en;
          next_itype[2*pin_sel_i +: 2] = pin_cfg_i.int_type;
        end
      end
      default: next_state = PDMC_ST_RESET;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state            <= PDMC_ST_RESET;
      for (int i = 0; i < `PDMC_NPINS; i++)
        dm[i] <= `PDMC_DM_HIZ_ANA;
      output_value_reg <= 8'h00;
      byp              <= 8'h00;
      die              <= 8'h00;
      itype            <= 16'h0000;
    end else begin
      state            <= next_state;
      dm               <= next_dm;
      output_value_reg <= next_output_value_reg;
      byp              <= next_byp;
      die              <= next_die;
      itype            <= next_itype;
    end
  end

  assign out_mux = (byp & fabric_out_i) | (~byp & output_value_reg);

  for (genvar g = 0; g < `PDMC_NPINS; g++) begin : g_pin
    pdmc_pin u_pin (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .drive_mode_i (dm[g]),
      .usb_pin_i    (is_usb[g]),
      .usb_mode_i   (usb_mode_i),
      .sio_reg_i    (sio_pin_i[g] & sio_regulated_i[g]),
      .out_val_i    (out_mux[g]),
      .pin_sync_i   (sync2[g]),
      .int_type_i   (itype[2*g +: 2]),
      .din_en_i     (die[g]),
      .pad_o        (pad[g]),
      .pin_level_o  (lvl[g]),
      .fabric_in_o  (fin[g]),
      .edge_o       (edg[g])
    );
  end

  // Pad drivers, events and readback
  always_comb begin
    for (int i = 0; i < `PDMC_NPINS; i++) begin
      next_pd_o[i]    = pad[i].out;
      next_pd_oe_n[i] = pad[i].out ? (pad[i].hi == PDMC_DRV_HIZ)
                                   : (pad[i].lo == PDMC_DRV_HIZ);
      next_pd_res[i]  = pad[i].out ? (pad[i].hi == PDMC_DRV_RES)
                                   : (pad[i].lo == PDMC_DRV_RES);
    end
    // Set beats clear
    next_stat = (stat & ~int_clear_i) | edg;
    next_irq  = |next_stat;
    next_rd_cfg = '{itype[2*pin_sel_i +: 2], die[pin_sel_i],
                    byp[pin_sel_i], output_value_reg[pin_sel_i],
                    dm[pin_sel_i]};
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pd_o    <= 8'h00;
      pd_oe_n <= 8'hFF;
      pd_res  <= 8'h00;
      stat    <= 8'h00;
      irq     <= 1'b0;
      rd_cfg  <= '0;
    end else begin
      pd_o    <= next_pd_o;
      pd_oe_n <= next_pd_oe_n;
      pd_res  <= next_pd_res;
      stat    <= next_stat;
      irq     <= next_irq;
      rd_cfg  <= next_rd_cfg;
    end
  end

  assign pin_o              = pd_o;
  assign pin_oe_n_o         = pd_oe_n;
  assign pin_res_o          = pd_res;
  assign pin_level_reg_o    = lvl;
  assign fabric_in_o        = fin;
  assign int_status_o       = stat;
  assign port_irq_o         = irq;
  assign pin_cfg_o          = rd_cfg;
  assign output_value_reg_o = output_value_reg;
endmodule

//--- sim/pdmc_port_sva.sv
`timescale 1ns/10ps
module pdmc_port_chk (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic [2:0]              pin_sel_i,
  input wire pdmc_pkg::pdmc_pin_cfg_t pin_cfg_i,
  input wire logic                    pin_wr_i,
  input wire logic [7:0]              port_output_value_reg_i,
  input wire logic                    port_dr_wr_i,
  input wire logic                    usb_present_i,
  input wire logic                    usb_mode_i,
  input wire logic [7:0]              int_clear_i,
  input wire logic [7:0]              pin_oe_n_o,
  input wire logic [7:0]              pin_level_reg_o,
  input wire logic [7:0]              fabric_in_o,
  input wire logic [7:0]              int_status_o,
  input wire logic                    port_irq_o,
  input wire pdmc_pkg::pdmc_pin_cfg_t pin_cfg_o,
  input wire logic [7:0]              output_value_reg_o
);
  import pdmc_pkg::*;
  logic [1:0] run_cnt;
  wire logic  run = (run_cnt == 2'h2);
  // Writes only count once the strap load is over
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_cnt <= 2'h0;
    end else if (!run) begin
      run_cnt <= run_cnt + 2'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_pin_wr;
    run && pin_wr_i ##1 $stable(pin_sel_i) [*2];
  endsequence
  sequence s_usb_on;
    (usb_present_i && usb_mode_i) [*4];
  endsequence
  reset_hiz_a: assert property (
    $fell(rst_i) |-> (pin_oe_n_o == 8'hFF) [*2]) else $error("pad driven");
  fabric_gate_a: assert property (
    (fabric_in_o & ~pin_level_reg_o) == 8'h00) else $error("fabric bit");
  irq_any_a: assert property (
    port_irq_o == (|int_status_o)) else $error("port request");
  status_hold_a: assert property (
    (($past(int_status_o) & ~$past(int_clear_i)) & ~int_status_o) == 8'h00)
    else $error("status lost");
  status_cause_a: assert property (
    ((int_status_o & ~$past(int_status_o)) & ~($past(pin_level_reg_o) ^
    $past(pin_level_reg_o, 2))) == 8'h00) else $error("status no edge");
  dr_write_a: assert property (
    run && port_dr_wr_i && !pin_wr_i |=>
    output_value_reg_o == $past(port_output_value_reg_i))
    else $error("output data write");
  cfg_read_a: assert property (
    s_pin_wr |=> pin_cfg_o == $past(pin_cfg_i, 3)) else $error("pin readback");
  usb_hiz_a: assert property (
    s_usb_on |-> pin_oe_n_o[7:6] == 2'h3) else $error("usb pad driven");
endmodule

bind pdmc_port pdmc_port_chk u_chk (
  .clk_i, .rst_i, .pin_sel_i, .pin_cfg_i, .pin_wr_i, .port_output_value_reg_i,
  .port_dr_wr_i, .usb_present_i, .usb_mode_i, .int_clear_i, .pin_oe_n_o,
  .pin_level_reg_o, .fabric_in_o, .int_status_o, .port_irq_o, .pin_cfg_o,
  .output_value_reg_o
);

//--- sim/pdmc_ext.sv
`timescale 1ns/10ps
module pdmc_ext (
  input  wire logic       clk_i,
  input  wire logic [7:0] pad_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] res_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pin_o
);
  logic [7:0] float_lvl = 8'h55;
  // Open pads wander so a stale level never reads back
  always @(posedge clk_i) float_lvl <= ~float_lvl;
  // Strong drive beats the load; the load beats a resistor
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      if (!oe_n_i[p] && !(res_i[p] && ext_en_i[p])) pin_o[p] = pad_i[p];
      else if (ext_en_i[p]) pin_o[p] = ext_val_i[p];
      else pin_o[p] = float_lvl[p];
    end
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  import pdmc_pkg::*;
  // Per {mode, data}: 0 open, 1 resistive, 2 strong
  localparam logic [31:0] DRV = 32'h5A829600;
  logic          clk_i, rst_i, port_dm_wr_i, port_dr_wr_i, port_cfg_wr_i;
  logic          pin_wr_i, usb_wr_i, usb_present_i, usb_mode_i, port_irq_o;
  logic [7:0]    reset_dm_high_i, reset_dm_mid_i, reset_dm_low_i;
  logic [7:0]    port_drive_mode_bit_high_i, port_drive_mode_bit_mid_i;
  logic [7:0]    port_drive_mode_bit_low_i, port_output_value_reg_i;
  logic [7:0]    hardware_output_select_i, din_en_i, fabric_out_i;
  logic [7:0]    usb_pin_drive_enable_bits_i, usb_pin_pull_enable_bits_i;
  logic [7:0]    sio_pin_i, sio_regulated_i, int_clear_i, pin_i, pin_o;
  logic [7:0]    pin_oe_n_o, pin_res_o, pin_level_reg_o, fabric_in_o;
  logic [7:0]    int_status_o, output_value_reg_o, ext_val, ext_en;
  logic [15:0]   int_type_i;
  logic [2:0]    pin_sel_i;
  pdmc_pin_cfg_t pin_cfg_i, pin_cfg_o;
  int            miscompares, comparisons;

  pdmc_port u_dut (
    .clk_i, .rst_i, .reset_dm_high_i, .reset_dm_mid_i, .reset_dm_low_i,
    .port_drive_mode_bit_high_i, .port_drive_mode_bit_mid_i,
    .port_drive_mode_bit_low_i, .port_dm_wr_i, .port_output_value_reg_i,
    .port_dr_wr_i, .hardware_output_select_i, .din_en_i, .int_type_i,
    .port_cfg_wr_i, .pin_sel_i, .pin_cfg_i, .pin_wr_i,
    .usb_pin_drive_enable_bits_i, .usb_pin_pull_enable_bits_i, .usb_wr_i,
    .usb_present_i, .usb_mode_i, .sio_pin_i, .sio_regulated_i, .fabric_out_i,
    .int_clear_i, .pin_i, .pin_o, .pin_oe_n_o, .pin_res_o, .pin_level_reg_o,
    .fabric_in_o, .int_status_o, .port_irq_o, .pin_cfg_o, .output_value_reg_o
  );
  pdmc_ext u_ext (
    .clk_i, .pad_i(pin_o), .oe_n_i(pin_oe_n_o), .res_i(pin_res_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_o(pin_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic chk_pad(input int p, input logic [2:0] m, input logic d);
    logic [1:0] e;
    e = DRV[2*{m, d} +: 2];
    chk({pin_oe_n_o[p], !pin_oe_n_o[p] & pin_res_o[p],
         !pin_oe_n_o[p] & pin_o[p]}, {e == 2'h0, e == 2'h1, e != 2'h0 && d});
  endtask

  // Pads settle two edges after the taking edge
  task automatic strobe(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    repeat (3) @(negedge clk_i);
  endtask

  task automatic set_dm(input logic [7:0] h, input logic [7:0] m,
                        input logic [7:0] l);
    port_drive_mode_bit_high_i = h;
    port_drive_mode_bit_mid_i = m;
    port_drive_mode_bit_low_i = l;
    strobe(port_dm_wr_i);
  endtask

  task automatic do_reset;
    rst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic clear_int;
    repeat (5) @(negedge clk_i);
    int_clear_i = 8'hFF;
    @(negedge clk_i);
    int_clear_i = 8'h00;
    @(negedge clk_i);
  endtask

  task automatic t_reset;
    do_reset;
    chk(pin_oe_n_o, 8'hFF);
    chk(pin_level_reg_o, 8'h00);
    chk(fabric_in_o, 8'h00);
    reset_dm_high_i = 8'hF0;
    reset_dm_mid_i = 8'hCC;
    reset_dm_low_i = 8'hAA;
    do_reset;
    for (int p = 0; p < 8; p++) chk_pad(p, 3'(p), 1'b0);
  endtask

  task automatic t_modes;
    ext_en = 8'h00;
    set_dm(8'hF0, 8'hCC, 8'hAA);
    for (int d = 0; d < 2; d++) begin
      port_output_value_reg_i = d[0] ? 8'hFF : 8'h00;
      strobe(port_dr_wr_i);
      for (int p = 0; p < 8; p++) chk_pad(p, 3'(p), d[0]);
    end
  endtask

  task automatic t_input;
    din_en_i = 8'h0F;
    strobe(port_cfg_wr_i);
    set_dm(8'h00, 8'h00, 8'hFF);
    ext_en = 8'hFF;
    repeat (4) @(negedge clk_i);
    chk(pin_level_reg_o, 8'h5A);
    chk(fabric_in_o, 8'h0A);
    set_dm(8'h00, 8'h00, 8'h00);
    @(negedge clk_i);
    chk(pin_level_reg_o, 8'h00);
    chk(fabric_in_o, 8'h00);
  endtask

  task automatic t_bypass;
    set_dm(8'hFF, 8'hFF, 8'h00);
    port_output_value_reg_i = 8'h0F;
    strobe(port_dr_wr_i);
    fabric_out_i = 8'h33;
    hardware_output_select_i = 8'hF0;
    strobe(port_cfg_wr_i);
    repeat (4) @(negedge clk_i);
    chk(pin_o, 8'h3F);
    chk(output_value_reg_o, 8'h0F);
    chk(pin_level_reg_o, 8'h3F);
  endtask

  task automatic t_pin;
    pin_sel_i = 3'h5;
    pin_cfg_i = 8'h6D;
    strobe(pin_wr_i);
    chk(pin_cfg_o, 8'h6D);
    chk(output_value_reg_o, 8'h2F);
    chk_pad(5, 3'h5, 1'b1);
    pin_sel_i = 3'h2;
    repeat (2) @(negedge clk_i);
    chk(pin_cfg_o, 8'h2E);
  endtask

  task automatic t_irq;
    int_type_i = 16'h0039;
    din_en_i = 8'hFF;
    strobe(port_cfg_wr_i);
    set_dm(8'h00, 8'h00, 8'hFF);
    ext_val = 8'h00;
    clear_int;
    ext_val = 8'h0F;
    repeat (5) @(negedge clk_i);
    chk(int_status_o, 8'h05);
    chk(port_irq_o, 1'b1);
    clear_int;
    chk(port_irq_o, 1'b0);
    ext_val = 8'h00;
    repeat (5) @(negedge clk_i);
    chk(int_status_o, 8'h06);
  endtask

  task automatic t_sio;
    sio_pin_i = 8'h01;
    sio_regulated_i = 8'h01;
    pin_sel_i = 3'h0;
    pin_cfg_i = 8'h07;
    strobe(pin_wr_i);
    chk_pad(0, 3'h6, 1'b0);
  endtask

  task automatic t_usb;
    // Bypass left over from t_bypass would feed pins 7,6 from the fabric
    hardware_output_select_i = 8'h00;
    strobe(port_cfg_wr_i);
    usb_present_i = 1'b1;
    usb_pin_pull_enable_bits_i = 8'h40;
    strobe(usb_wr_i);
    for (int d = 0; d < 2; d++) begin
      port_output_value_reg_i = d[0] ? 8'hC0 : 8'h00;
      strobe(port_dr_wr_i);
      chk_pad(7, 3'h4, d[0]);
      chk_pad(6, 3'h2, d[0]);
    end
    usb_pin_drive_enable_bits_i = 8'hC0;
    strobe(usb_wr_i);
    set_dm(8'h00, 8'h00, 8'h00);
    chk_pad(7, 3'h6, 1'b1);
    chk_pad(6, 3'h6, 1'b1);
    usb_mode_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(pin_oe_n_o[7:6], 2'h3);
  endtask

  task automatic conclude;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rst_i = 1'b1;
    {port_dm_wr_i, port_dr_wr_i, port_cfg_wr_i, pin_wr_i, usb_wr_i} = '0;
    {usb_present_i, usb_mode_i, pin_sel_i, pin_cfg_i, int_type_i} = '0;
    {reset_dm_high_i, reset_dm_mid_i, reset_dm_low_i} = '0;
    {port_drive_mode_bit_high_i, port_drive_mode_bit_mid_i} = '0;
    {port_drive_mode_bit_low_i, port_output_value_reg_i, din_en_i} = '0;
    {hardware_output_select_i, fabric_out_i, sio_pin_i} = '0;
    {usb_pin_drive_enable_bits_i, usb_pin_pull_enable_bits_i} = '0;
    {sio_regulated_i, int_clear_i} = '0;
    ext_val = 8'h5A;
    ext_en = 8'hFF;
    t_reset;
    t_modes;
    t_input;
    t_bypass;
    t_pin;
    t_irq;
    t_sio;
    t_usb;
    conclude;
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    conclude;
  end
endmodule
